// File: include/tlic_pkg.sv
package tlic_pkg;

  // ****************************************
  // source map
  // ****************************************
  localparam int          NSRC        = 21;
  localparam logic [20:0] SRC_VALID   = 21'h17ffff;  // slot 19 is unused
  localparam logic [4:0]  SRC_CMP1_RISE = 5'h0d;
  localparam logic [4:0]  SRC_ADC0_DONE = 5'h0f;
  localparam logic [4:0]  SRC_ADC2_DONE = 5'h12;
  localparam logic [15:0] VEC_BASE    = 16'h0003;
  localparam logic [15:0] VEC_STEP    = 16'h0008;

  // ****************************************
  // timing
  // ****************************************
  localparam logic [2:0]  CALL_CYCLES = 3'h4;        // long call length

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0]  ADR_IE      = 8'h00;
  localparam logic [7:0]  ADR_EXT_ENABLE_REG_1    = 8'h04;
  localparam logic [7:0]  ADR_EXT_ENABLE_REG_2    = 8'h08;
  localparam logic [7:0]  ADR_IP      = 8'h0c;
  localparam logic [7:0]  ADR_EXT_PRIORITY_REG_1    = 8'h10;
  localparam logic [7:0]  ADR_EXT_PRIORITY_REG_2    = 8'h14;
  localparam logic [7:0]  ADR_STAT    = 8'h18;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam int          GLOBAL_BIT  = 7;
  localparam logic [7:0]  IE_SRC_MASK = 8'h3f;
  localparam logic [7:0]  EXT_ENABLE_REG_2_MASK   = 8'h5f;       // bit 5 and 7 unused

  typedef enum logic {
    TLIC_IDLE,
    TLIC_CALL
  } tlic_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } tlic_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tlic_wb_rsp_t;

  typedef struct packed {
    logic instr_done;
    logic reti;
    logic cache_fill;
  } tlic_cpu_in_t;

  typedef struct packed {
    logic        lcall;
    logic [15:0] vec;
    logic        taken;
    logic [4:0]  src;
  } tlic_cpu_out_t;

endpackage

// File: hw/tlic_ctrl.sv
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ns
// Functional notes
// - comparator 1 rising edge vectors to 0x006B, position 13, own enable.
// - adc0 end of conversion vectors to 0x007B, position 15, own enable.
// - adc2 end of conversion vectors to 0x0093, position 18, own enable.
// - each source is programmed to low or high priority.
// - a high request preempts a running low routine.
// - a running high routine is never preempted.
// - each source has a priority bit; set means high.
// - all priority bits reset to low.
// - simultaneous requests at different levels: high served first.
// - same level: lowest fixed position number wins.
// - pending requests sampled and decoded every clock.
// - minimum response five cycles: one detect, four long call.
// - vector fetch cache miss stretches the response until filled.
// - after return, one more instruction runs before the next call.
// - equal or lower request waits for return plus one instruction.
// - global enable bit 7 low blocks every source.
// - global enable high: each source follows its own enable.
// - enable bit 6 is a scratch flag without hardware effect.
// - individual enable bit: 0 disables, 1 enables its source.
// - flag still set after return requests again after one instruction.
// - software setting a pending flag requests like hardware, enables apply.
module tlic_ctrl (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire tlic_pkg::tlic_wb_req_t wb_req,
  output      tlic_pkg::tlic_wb_rsp_t wb_rsp,
  input  wire logic [20:0]            pend_flags,
  input  wire tlic_pkg::tlic_cpu_in_t cpu_in,
  output      tlic_pkg::tlic_cpu_out_t cpu_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tlic_pkg::tlic_state_t fsm;
    logic [2:0]            cnt;
    logic                  act_hi;
    logic                  act_lo;
    logic                  hold;
    logic [7:0]            ie;
    logic [7:0]            ext_enable_reg_1;
    logic [7:0]            ext_enable_reg_2;
    logic [7:0]            ip;
    logic [7:0]            ext_priority_reg_1;
    logic [7:0]            ext_priority_reg_2;
    logic                  src_hi;
    tlic_pkg::tlic_cpu_out_t cpu;
    tlic_pkg::tlic_wb_rsp_t  wb;
  } tlic_regs_t;

  tlic_regs_t st_ff;
  tlic_regs_t nxt_st;

  // ****************************************
  // helpers
  // ****************************************
  // spread three byte registers over the fixed source positions
  function automatic logic [20:0] src_map(input logic [7:0] r0, input logic [7:0] r1,
                                          input logic [7:0] r2);
    src_map = {r2[6:0], r1, r0[5:0]} & tlic_pkg::SRC_VALID;
  endfunction

  // lowest position wins
  function automatic logic [4:0] pick(input logic [20:0] req);
    pick = 5'h00;
    for (int i = tlic_pkg::NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick = 5'(i);
      end
    end
  endfunction

  function automatic logic [15:0] vec_of(input logic [4:0] s);
    vec_of = tlic_pkg::VEC_BASE + 16'(s) * tlic_pkg::VEC_STEP;
  endfunction

  logic [20:0] en_mask;
  logic [20:0] hi_mask;
  logic [20:0] req;
  logic [20:0] req_hi;
  logic        any_hi;
  logic [4:0]  win;
  logic        win_hi;
  logic        allow;
  logic        go;
  logic        wr;
  logic [7:0]  rd;

  // ****************************************
  // arbitration, every cycle
  // ****************************************
  always_comb begin
    en_mask = src_map(st_ff.ie, st_ff.ext_enable_reg_1, st_ff.ext_enable_reg_2);
    hi_mask = src_map(st_ff.ip, st_ff.ext_priority_reg_1, st_ff.ext_priority_reg_2);
    req     = st_ff.ie[tlic_pkg::GLOBAL_BIT] ? (pend_flags & en_mask) : '0;
    req_hi  = req & hi_mask;
    any_hi  = |req_hi;
    win     = any_hi ? pick(req_hi) : pick(req);
    win_hi  = any_hi;
    // low service only yields to high; high yields to nothing
    allow   = !st_ff.act_hi && (!st_ff.act_lo || win_hi);
    go      = (st_ff.fsm == tlic_pkg::TLIC_IDLE) && |req && allow && !st_ff.hold && !cpu_in.reti;
  end

  // ****************************************
  // register bus
  // ****************************************
  always_comb begin
    wr = wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0] && st_ff.wb.ack;
    unique case (wb_req.adr)
      tlic_pkg::ADR_IE:   rd = st_ff.ie;
      tlic_pkg::ADR_EXT_ENABLE_REG_1: rd = st_ff.ext_enable_reg_1;
      tlic_pkg::ADR_EXT_ENABLE_REG_2: rd = st_ff.ext_enable_reg_2;
      tlic_pkg::ADR_IP:   rd = st_ff.ip;
      tlic_pkg::ADR_EXT_PRIORITY_REG_1: rd = st_ff.ext_priority_reg_1;
      tlic_pkg::ADR_EXT_PRIORITY_REG_2: rd = st_ff.ext_priority_reg_2;
      tlic_pkg::ADR_STAT: rd = {st_ff.act_hi, st_ff.act_lo, st_ff.hold, st_ff.cpu.src};
      default:            rd = 8'h00;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cpu.taken = 1'b0;
    nxt_st.wb.ack = wb_req.cyc && wb_req.stb && !st_ff.wb.ack;
    nxt_st.wb.dat = {24'h000000, rd};
    if (wr) begin
      unique case (wb_req.adr)
        tlic_pkg::ADR_IE:   nxt_st.ie   = wb_req.dat[7:0];
        tlic_pkg::ADR_EXT_ENABLE_REG_1: nxt_st.ext_enable_reg_1 = wb_req.dat[7:0];
        tlic_pkg::ADR_EXT_ENABLE_REG_2: nxt_st.ext_enable_reg_2 = wb_req.dat[7:0] & tlic_pkg::EXT_ENABLE_REG_2_MASK;
        tlic_pkg::ADR_IP:   nxt_st.ip   = wb_req.dat[7:0] & tlic_pkg::IE_SRC_MASK;
        tlic_pkg::ADR_EXT_PRIORITY_REG_1: nxt_st.ext_priority_reg_1 = wb_req.dat[7:0];
        tlic_pkg::ADR_EXT_PRIORITY_REG_2: nxt_st.ext_priority_reg_2 = wb_req.dat[7:0] & tlic_pkg::EXT_ENABLE_REG_2_MASK;
        default: ;
      endcase
    end
    // return: drop the innermost level, then let one instruction pass
    if (cpu_in.reti) begin
      nxt_st.hold = 1'b1;
      if (st_ff.act_hi) begin
        nxt_st.act_hi = 1'b0;
      end else begin
        nxt_st.act_lo = 1'b0;
      end
    end else if (cpu_in.instr_done) begin
      nxt_st.hold = 1'b0;
    end
    unique case (st_ff.fsm)
      tlic_pkg::TLIC_IDLE: begin
        if (go) begin
          nxt_st.fsm       = tlic_pkg::TLIC_CALL;
          nxt_st.cnt       = tlic_pkg::CALL_CYCLES - 3'h1;
          nxt_st.cpu.lcall = 1'b1;
          nxt_st.cpu.vec   = vec_of(win);
          nxt_st.cpu.src   = win;
          nxt_st.src_hi    = win_hi;
        end
      end
      tlic_pkg::TLIC_CALL: begin
        if (st_ff.cnt != 3'h0) begin
          nxt_st.cnt = st_ff.cnt - 3'h1;
        end else if (!cpu_in.cache_fill) begin
          nxt_st.fsm       = tlic_pkg::TLIC_IDLE;
          nxt_st.cpu.lcall = 1'b0;
          nxt_st.cpu.taken = 1'b1;
          if (st_ff.src_hi) begin
            nxt_st.act_hi = 1'b1;
          end else begin
            nxt_st.act_lo = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff      <= '0;
      st_ff.fsm  <= tlic_pkg::TLIC_IDLE;
      st_ff.ie   <= tlic_pkg::REG_RESET;
      st_ff.ip   <= tlic_pkg::REG_RESET;
      st_ff.ext_priority_reg_1 <= tlic_pkg::REG_RESET;
      st_ff.ext_priority_reg_2 <= tlic_pkg::REG_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_rsp  = st_ff.wb;
  assign cpu_out = st_ff.cpu;

  // ****************************************
  // checks
  // ****************************************
  a_call_four_cycles: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_ff.cpu.lcall) |-> st_ff.cpu.lcall [*4] ##1 (st_ff.cpu.taken || cpu_in.cache_fill || st_ff.cpu.lcall))
    else $error("long call shorter than four cycles");

  a_fill_stretch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.lcall && st_ff.cnt == 3'h0 && cpu_in.cache_fill |=> st_ff.cpu.lcall && !st_ff.cpu.taken)
    else $error("call ended during cache fill");

  a_global_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st_ff.ie[7] && !st_ff.cpu.lcall |=> !st_ff.cpu.lcall)
    else $error("call started with global enable low");

  a_own_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_ff.cpu.lcall) |-> |($past(en_mask & pend_flags) & (21'h000001 << st_ff.cpu.src)))
    else $error("disabled or idle source vectored");

  a_high_no_preempt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.act_hi && !cpu_in.reti |=> !$rose(st_ff.cpu.lcall))
    else $error("high routine preempted");

  a_high_preempts: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.act_lo && !st_ff.act_hi && !st_ff.hold && st_ff.fsm == tlic_pkg::TLIC_IDLE && !cpu_in.reti
    && |(pend_flags & en_mask & hi_mask) && st_ff.ie[7] |=> $rose(st_ff.cpu.lcall) && st_ff.src_hi)
    else $error("high request failed to preempt low routine");

  a_high_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && |req_hi |=> st_ff.src_hi)
    else $error("low request served before high");

  a_lowest_pos: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go |-> ((req & (win_hi ? hi_mask : ~hi_mask) & ((21'h000001 << win) - 21'h000001)) == '0))
    else $error("higher position chosen over lower");

  a_one_instr_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_in.reti |=> !$rose(st_ff.cpu.lcall) ##0 (!go throughout (!cpu_in.instr_done [*1])))
    else $error("call made before one instruction after return");

  a_vector_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_ff.cpu.lcall) && st_ff.cpu.src == tlic_pkg::SRC_CMP1_RISE |-> st_ff.cpu.vec == 16'h006b)
    else $error("wrong comparator vector");

  // ****************************************
  // bus and state checks
  // ****************************************
  a_ack_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.wb.ack |=> !st_ff.wb.ack)
    else $error("ack held longer than one cycle");

  a_ack_after_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wb_req.cyc && wb_req.stb && !st_ff.wb.ack |=> st_ff.wb.ack)
    else $error("request not acked");

  a_ack_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(wb_req.cyc && wb_req.stb) |=> !st_ff.wb.ack)
    else $error("ack without request");

  a_rd_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.wb.dat[31:8] == 24'h000000)
    else $error("read data upper bits set");

  a_ie_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr && wb_req.adr == tlic_pkg::ADR_IE |=> st_ff.ie == $past(wb_req.dat[7:0]))
    else $error("enable write lost");

  a_ip_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_ff.ip & ~tlic_pkg::IE_SRC_MASK) == 8'h00)
    else $error("unused priority bits set");

  a_ext_enable_reg_2_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_ff.ext_enable_reg_2 & ~tlic_pkg::EXT_ENABLE_REG_2_MASK) == 8'h00)
    else $error("unused enable bits set");

  a_ext_priority_reg_2_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_ff.ext_priority_reg_2 & ~tlic_pkg::EXT_ENABLE_REG_2_MASK) == 8'h00)
    else $error("unused priority bits set");

  a_taken_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.taken |=> !st_ff.cpu.taken)
    else $error("taken longer than one cycle");

  a_taken_ends: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.taken |-> !st_ff.cpu.lcall && $past(st_ff.cpu.lcall))
    else $error("taken without a finished call");

  a_call_fsm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.lcall == (st_ff.fsm == tlic_pkg::TLIC_CALL))
    else $error("call flag out of step with state");

  a_adc0_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.lcall && st_ff.cpu.src == tlic_pkg::SRC_ADC0_DONE |-> st_ff.cpu.vec == 16'h007b)
    else $error("wrong adc0 vector");

  a_adc2_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.lcall && st_ff.cpu.src == tlic_pkg::SRC_ADC2_DONE |-> st_ff.cpu.vec == 16'h0093)
    else $error("wrong adc2 vector");

  a_src_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.lcall |-> st_ff.cpu.src != 5'h13 && st_ff.cpu.src <= 5'h14)
    else $error("reserved or missing slot vectored");

  a_global_past: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_ff.cpu.lcall) |-> $past(st_ff.ie[tlic_pkg::GLOBAL_BIT]))
    else $error("call with global enable low");

  a_reti_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_in.reti |=> !$rose(st_ff.cpu.lcall))
    else $error("call in return cycle");

  a_hold_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.hold |=> !$rose(st_ff.cpu.lcall))
    else $error("call before instruction after return");

  a_low_preempt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_ff.cpu.lcall) && $past(st_ff.act_lo) |-> st_ff.src_hi)
    else $error("low routine preempted by low request");

  a_hi_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_ff.cpu.lcall) |-> !$past(st_ff.act_hi))
    else $error("call during high routine");

  a_pop_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_in.reti && st_ff.act_hi && st_ff.fsm == tlic_pkg::TLIC_IDLE
    |=> !st_ff.act_hi && st_ff.act_lo == $past(st_ff.act_lo))
    else $error("return popped wrong level");

  a_pop_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_in.reti && !st_ff.act_hi && st_ff.fsm == tlic_pkg::TLIC_IDLE |=> !st_ff.act_lo)
    else $error("return left low level active");

  a_hold_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_in.reti |=> st_ff.hold)
    else $error("return did not hold");

  a_hold_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cpu_in.reti && cpu_in.instr_done |=> !st_ff.hold)
    else $error("hold not released");

  a_push_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.taken && st_ff.src_hi |-> st_ff.act_hi)
    else $error("high level not entered");

  a_push_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.taken && !st_ff.src_hi |-> st_ff.act_lo)
    else $error("low level not entered");

  a_level_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_ff.cpu.lcall) |-> st_ff.src_hi == |($past(hi_mask) & (21'h000001 << st_ff.cpu.src)))
    else $error("level differs from priority bit");

  a_call_needs_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_ff.cpu.lcall) |-> $past(|req))
    else $error("call without request");

  a_req_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st_ff.ie[tlic_pkg::GLOBAL_BIT] |-> req == '0)
    else $error("request passed global enable");

  a_req_enabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req & ~en_mask) == '0)
    else $error("disabled source requested");

  a_reserved_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !req[19])
    else $error("reserved slot requested");

  a_vec_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.lcall && !$rose(st_ff.cpu.lcall) |-> $stable(st_ff.cpu.vec))
    else $error("vector moved during call");

  a_taken_no_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.cpu.taken |-> !$past(cpu_in.cache_fill))
    else $error("call ended while cache filled");

endmodule // tlic_ctrl

// File: tb/tlic_cpu_mdl.sv
`timescale 1ns/1ns
// ****
// core and flag sources
// ****
module tlic_cpu_mdl (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire tlic_pkg::tlic_cpu_out_t cpu_out,
  input  wire logic [20:0]             set_f,
  input  wire logic [20:0]             clr_f,
  input  wire logic                    ret_go,
  input  wire logic [3:0]              fill_n,
  output      logic [20:0]             pend_flags,
  output      tlic_pkg::tlic_cpu_in_t  cpu_in
);
  logic [3:0] gap_ff;
  logic [3:0] fill_ff;
  logic       lc_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_flags <= '0;
      cpu_in <= '0;
      gap_ff <= '0;
      fill_ff <= '0;
      lc_ff <= 1'b0;
    end else begin
      // flags stay set until cleared, so leftovers re-request
      pend_flags <= (pend_flags | set_f) & ~clr_f;
      cpu_in.reti <= ret_go;
      gap_ff <= ret_go ? 4'h4 : gap_ff - {3'h0, |gap_ff};
      cpu_in.instr_done <= (gap_ff == 4'h1);
      lc_ff <= cpu_out.lcall;
      fill_ff <= (cpu_out.lcall && !lc_ff) ? fill_n : fill_ff - {3'h0, |fill_ff};
      cpu_in.cache_fill <= |fill_ff;
    end
  end
endmodule // tlic_cpu_mdl

// File: tb/tb_top.sv
`timescale 1ns/1ns
// ****
// bench top
// ****
module tb_top;
  logic                    clk_sys;
  logic                    rst_n;
  tlic_pkg::tlic_wb_req_t  wb_req;
  tlic_pkg::tlic_wb_rsp_t  wb_rsp;
  tlic_pkg::tlic_cpu_in_t  cpu_in;
  tlic_pkg::tlic_cpu_out_t cpu_out;
  logic [20:0]             pend_flags, set_f, clr_f, en_m, pr_m, pm;
  logic [31:0]             q;
  logic [3:0]              fill_n;
  logic                    ret_go, ea;
  int                      n_errors, checks_done, seed, ah, al, n, k;
  logic [7:0]              msk [7];
  int                      srcs [10];
  tlic_ctrl tlic_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .pend_flags(pend_flags), .cpu_in(cpu_in), .cpu_out(cpu_out));
  tlic_cpu_mdl tlic_cpu_mdl_i (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_out(cpu_out), .set_f(set_f),
    .clr_f(clr_f), .ret_go(ret_go), .fill_n(fill_n), .pend_flags(pend_flags), .cpu_in(cpu_in));
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    checks_done++;
    if (v !== e) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, v, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    wb_req <= {2'h3, w, 4'hf, a, d};
    for (i = 0; i < 20 && wb_rsp.ack !== 1'b1; i++) @(posedge clk_sys);
    if (i == 20) begin
      n_errors++;
      print_verdict();
    end
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic cfg(input logic g, input logic [20:0] e, input logic [20:0] p);
    // global off first so no call starts halfway through the setup
    bus(8'h00, 1'b1, 32'h0);
    bus(8'h04, 1'b1, {24'h0, e[13:6]});
    bus(8'h08, 1'b1, {25'h0, e[20], 1'b0, e[18:14]});
    bus(8'h0c, 1'b1, {26'h0, p[5:0]});
    bus(8'h10, 1'b1, {24'h0, p[13:6]});
    bus(8'h14, 1'b1, {25'h0, p[20], 1'b0, p[18:14]});
    bus(8'h00, 1'b1, {24'h0, g, 1'b0, e[5:0]});
    ea = g;
    en_m = e & 21'h17ffff;
    pr_m = p;
  endtask
  // lowest position wins inside a level; slot 19 never requests
  function automatic int pick();
    logic [20:0] c;
    c = ea ? pm & en_m : 21'h0;
    for (int i = 0; i < 21; i++) if (c[i] && pr_m[i] && ah == 0) return i;
    for (int i = 0; i < 21; i++) if (c[i] && !pr_m[i] && ah + al == 0) return i;
    return -1;
  endfunction
  task automatic fl(input logic [20:0] s, input logic [20:0] c);
    set_f <= s;
    clr_f <= c;
    pm = (pm | s) & ~c;
    @(posedge clk_sys);
    set_f <= '0;
    clr_f <= '0;
  endtask
  task automatic quiet(input int m);
    repeat (m) begin
      @(posedge clk_sys);
      chk(cpu_out.lcall, 0);
    end
  endtask
  task automatic serve(output int t);
    int e, i;
    e = pick();
    for (i = 0; i < 30 && cpu_out.lcall !== 1'b1; i++) @(posedge clk_sys);
    chk(cpu_out.src, e);
    chk(cpu_out.vec, 32'h3 + 32'h8 * e);
    for (t = 0; t < 40 && cpu_out.taken !== 1'b1; t++) @(posedge clk_sys);
    if (i == 30 || t == 40) begin
      n_errors++;
      print_verdict();
    end
    if (pr_m[e]) ah = 1;
    else al = 1;
  endtask
  task automatic ret(input logic [20:0] c);
    ret_go <= 1'b1;
    fl('0, c);
    ret_go <= 1'b0;
    if (ah != 0) ah = 0;
    else al = 0;
    quiet(4);
    repeat (3) @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {wb_req, set_f, clr_f, ret_go, fill_n, rst_n, pm, en_m, pr_m, ea} = '0;
    {seed, ah, al, n_errors, checks_done} = {32'd12, 128'd0};
    msk = '{8'hff, 8'hff, 8'h5f, 8'h3f, 8'hff, 8'h5f, 8'h00};
    srcs = '{0, 5, 6, 13, 14, 15, 16, 17, 18, 20};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (k = 0; k < 7; k++) begin
      bus(8'(4 * k), 1'b0, 32'h0);
      chk(q, 0);
      n = $random(seed);
      bus(8'(4 * k), 1'b1, n);
      bus(8'(4 * k), 1'b0, 32'h0);
      chk(q, n & msk[k]);
    end
    bus(8'h1c, 1'b1, 32'hff);
    bus(8'h1c, 1'b0, 32'h0);
    chk(q, 0);
    $display("registers done");
    cfg(1'b0, '1, '0);
    fl(21'h2000, '0);
    quiet(8);
    cfg(1'b1, '1, '0);
    serve(n);
    chk(n, 4);
    ret('0);
    serve(n);
    ret(21'h2000);
    $display("gating done");
    for (k = 0; k < 10; k++) begin
      cfg(1'b1, ~(21'h1 << srcs[k]), '0);
      fl(21'h1 << srcs[k], '0);
      quiet(6);
      cfg(1'b1, '1, '0);
      serve(n);
      ret(21'h1 << srcs[k]);
    end
    $display("sources done");
    cfg(1'b1, '1, 21'h18000);
    fl(21'h0a000, '0);
    serve(n);
    fl(21'h10000, '0);
    quiet(8);
    ret(21'h8000);
    serve(n);
    ret(21'h10000);
    serve(n);
    fl(21'h40000, '0);
    quiet(6);
    fl(21'h8000, '0);
    serve(n);
    ret(21'h8000);
    ret(21'h2000);
    serve(n);
    ret(21'h40000);
    fl(21'h110000, '0);
    serve(n);
    ret(21'h10000);
    serve(n);
    ret(21'h100000);
    $display("priority done");
    fill_n <= 4'h6;
    fl(21'h2000, '0);
    serve(n);
    chk(n > 4 && n < 12, 1);
    ret(21'h2000);
    $display("fill done");
    print_verdict();
  end
endmodule // tb_top
